// File: test/oda_alu_assertions.sv
// Concurrent checks on the unit's top ports.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
module oda_alu_assertions (
  input wire logic                       clock,
  input wire logic                       nrst,
  input wire logic                       op_valid,
  input wire oda_pkg::oda_op_type        op_code,
  input wire logic [2:0]                 src1_sel,
  input wire logic [2:0]                 src2_sel,
  input wire logic [2:0]                 dst_sel,
  input wire logic                       use_imm,
  input wire logic                       cond_true,
  input wire logic                       rd0_valid,
  input wire logic [2:0]                 rd0_sel,
  input wire logic                       rd1_valid,
  input wire logic [2:0]                 rd1_sel,
  input wire logic [oda_pkg::WORD_W-1:0] rd1_data,
  input wire logic [2:0]                 wr_sel,
  input wire logic [oda_pkg::WORD_W-1:0] wr_data,
  input wire logic                       flag_carry,
  input wire logic                       flag_zero,
  input wire logic                       flag_neg,
  input wire logic                       flag_ovf,
  input wire logic                       flag_limit
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_limit_sticky;
    flag_limit |=> flag_limit;
  endproperty
  a_limit_sticky: assert property (p_limit_sticky) else $error("limit flag dropped");

  property p_tcc_flags;
    op_valid && op_code == oda_pkg::OP_TCC |=> $stable({flag_carry, flag_zero, flag_neg, flag_ovf, flag_limit});
  endproperty
  a_tcc_flags: assert property (p_tcc_flags) else $error("move changed flags");

  property p_cmp_nowrite;
    op_valid && op_code == oda_pkg::OP_CMP && !rd0_valid && !rd1_valid ##1 wr_sel == $past(wr_sel) |-> $stable(wr_data);
  endproperty
  a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare wrote a register");

  property p_dst_none;
    op_valid && dst_sel > 3'h4 && !rd0_valid && !rd1_valid |=> wr_sel != $past(wr_sel) || $stable(wr_data);
  endproperty
  a_dst_none: assert property (p_dst_none) else $error("write to no register changed one");

  property p_tcc_false;
    op_valid && op_code == oda_pkg::OP_TCC && !cond_true && !rd0_valid && !rd1_valid ##1 wr_sel == $past(wr_sel)
      |-> $stable(wr_data);
  endproperty
  a_tcc_false: assert property (p_tcc_false) else $error("false move wrote a register");

  property p_load_rd1;
    !op_valid && rd1_valid && rd1_sel == 3'h1 ##1 wr_sel == 3'h1 |-> wr_data == $past(rd1_data);
  endproperty
  a_load_rd1: assert property (p_load_rd1) else $error("bus load not visible next cycle");

  property p_rd1_wins;
    !op_valid && rd0_valid && rd1_valid && rd0_sel == 3'h2 && rd1_sel == 3'h2 |=> wr_sel != 3'h2 || wr_data == $past(rd1_data);
  endproperty
  a_rd1_wins: assert property (p_rd1_wins) else $error("bus priority wrong");

  property p_eor_zero;
    op_valid && op_code == oda_pkg::OP_EOR && !use_imm && src1_sel == src2_sel && src1_sel < 3'h5 && dst_sel < 3'h5
      |=> flag_zero;
  endproperty
  a_eor_zero: assert property (p_eor_zero) else $error("self xor not zero");

  c_mac: cover property (op_valid && op_code == oda_pkg::OP_MAC);
  c_limit: cover property ($rose(flag_limit));
  c_dual: cover property (rd0_valid && rd1_valid);
endmodule

bind oda_alu oda_alu_assertions oda_alu_assertions_i (.clock, .nrst, .op_valid, .op_code, .src1_sel, .src2_sel,
  .dst_sel, .use_imm, .cond_true, .rd0_valid, .rd0_sel, .rd1_valid, .rd1_sel, .rd1_data, .wr_sel, .wr_data,
  .flag_carry, .flag_zero, .flag_neg, .flag_ovf, .flag_limit);

// File: test/oda_mem_model.sv
// Two data-memory read buses over a fixed table.
// Assumes requests rise after an edge and hold one cycle.
`timescale 1ns/1ps
module oda_mem_model (
  input  wire logic        clock,
  input  wire logic        rq0,
  input  wire logic [1:0]  ad0,
  input  wire logic        rq1,
  input  wire logic [1:0]  ad1,
  output logic             rd0_valid,
  output logic      [15:0] rd0_data,
  output logic             rd1_valid,
  output logic      [15:0] rd1_data
);
  localparam logic [15:0] MEM [4] = '{16'h0003, 16'h0005, 16'h4001, 16'h4000};
  logic [15:0] last0_q = 16'h0000;
  logic [15:0] last1_q = 16'h0000;
  // Idle buses toggle so a stale word never looks valid
  assign rd0_valid = rq0;
  assign rd1_valid = rq1;
  assign rd0_data  = rq0 ? MEM[ad0] : ~last0_q;
  assign rd1_data  = rq1 ? MEM[ad1] : ~last1_q;
  always_ff @(posedge clock) begin
    last0_q <= rd0_data;
    last1_q <= rd1_data;
  end
endmodule

// File: test/tb_orthogonal_dsp_data_alu.sv
// Self-checking bench with the memory bus model.
// Assumes the package compiles first; checker binds in.
`timescale 1ns/1ps
module tb_orthogonal_dsp_data_alu;
  // ********************
  // Stimulus table
  // ********************
  // Flags field: use_imm, frac_mode, round_en, negate_en, sat_en, cond_true
  typedef struct packed {
    oda_pkg::oda_op_type op;
    logic [2:0]          s1, s2, dst, ws;
    logic [5:0]          fl;
    logic [15:0]         imm, ex;
  } oda_row_type;
  oda_row_type rows [30] = '{
    '{oda_pkg::OP_ADD,3'h0,3'h1,3'h2,3'h2,6'h01,16'h0000,16'h0008},
    '{oda_pkg::OP_ADD,3'h0,3'h0,3'h3,3'h3,6'h21,16'h0010,16'h0013},
    '{oda_pkg::OP_SUB,3'h1,3'h0,3'h4,3'h4,6'h01,16'h0000,16'h0002},
    '{oda_pkg::OP_OR,3'h1,3'h0,3'h1,3'h1,6'h21,16'h000a,16'h000f},
    '{oda_pkg::OP_EOR,3'h2,3'h0,3'h2,3'h2,6'h21,16'h00ff,16'h00f7},
    '{oda_pkg::OP_INC,3'h4,3'h0,3'h4,3'h4,6'h01,16'h0000,16'h0003},
    '{oda_pkg::OP_DEC,3'h0,3'h0,3'h0,3'h0,6'h01,16'h0000,16'h0002},
    '{oda_pkg::OP_MPY,3'h3,3'h4,3'h2,3'h2,6'h01,16'h0000,16'h0039},
    '{oda_pkg::OP_MPY,3'h0,3'h0,3'h3,3'h3,6'h01,16'h0000,16'h0004},
    '{oda_pkg::OP_MAC,3'h0,3'h1,3'h3,3'h3,6'h01,16'h0000,16'h0022},
    '{oda_pkg::OP_NEG,3'h0,3'h0,3'h0,3'h0,6'h01,16'h0000,16'hfffe},
    '{oda_pkg::OP_ASL,3'h1,3'h0,3'h1,3'h1,6'h01,16'h0000,16'h001e},
    '{oda_pkg::OP_BSL,3'h2,3'h0,3'h2,3'h2,6'h21,16'h0004,16'h0390},
    '{oda_pkg::OP_LSR,3'h0,3'h0,3'h0,3'h0,6'h01,16'h0000,16'h7fff},
    '{oda_pkg::OP_NOT,3'h1,3'h0,3'h1,3'h1,6'h01,16'h0000,16'hffe1},
    '{oda_pkg::OP_ABS,3'h1,3'h0,3'h1,3'h1,6'h01,16'h0000,16'h001f},
    '{oda_pkg::OP_TCC,3'h2,3'h0,3'h0,3'h0,6'h01,16'h0000,16'h0390},
    '{oda_pkg::OP_TCC,3'h1,3'h0,3'h0,3'h0,6'h00,16'h0000,16'h0390},
    '{oda_pkg::OP_CMP,3'h1,3'h0,3'h0,3'h0,6'h01,16'h0000,16'h0390},
    '{oda_pkg::OP_ADD,3'h1,3'h0,3'h7,3'h0,6'h01,16'h0000,16'h0390},
    '{oda_pkg::OP_ADD,3'h0,3'h0,3'h1,3'h1,6'h21,16'hfc70,16'h0000},
    '{oda_pkg::OP_ADC,3'h1,3'h0,3'h1,3'h1,6'h21,16'h0000,16'h0001},
    '{oda_pkg::OP_EOR,3'h0,3'h0,3'h0,3'h0,6'h01,16'h0000,16'h0000},
    '{oda_pkg::OP_MPY,3'h0,3'h1,3'h3,3'h3,6'h19,16'h0000,16'h2001},
    '{oda_pkg::OP_MPY,3'h0,3'h1,3'h4,3'h4,6'h11,16'h0000,16'h2000},
    '{oda_pkg::OP_MPY,3'h0,3'h1,3'h3,3'h3,6'h15,16'h0000,16'hdfff},
    '{oda_pkg::OP_MAC,3'h1,3'h1,3'h4,3'h4,6'h11,16'h0000,16'h4000},
    '{oda_pkg::OP_ADD,3'h3,3'h3,3'h0,3'h0,6'h13,16'h0000,16'h7fff},
    '{oda_pkg::OP_ADD,3'h3,3'h3,3'h2,3'h2,6'h11,16'h0000,16'h8000},
    '{oda_pkg::OP_MPY,3'h2,3'h0,3'h0,3'h0,6'h31,16'hffff,16'h0009}
  };
  logic                clock, nrst, op_valid, use_imm, frac_mode, unsigned_mode, round_en, negate_en, sat_en;
  logic                cond_true, rq0, rq1, rd0_valid, rd1_valid;
  logic                flag_carry, flag_zero, flag_neg, flag_ovf, flag_limit;
  oda_pkg::oda_op_type op_code;
  logic [2:0]          src1_sel, src2_sel, dst_sel, rd0_sel, rd1_sel, wr_sel;
  logic [1:0]          ad0, ad1;
  logic [15:0]         imm, rd0_data, rd1_data, wr_data;
  int                  num_errors = 0;
  int                  n_tests = 0;

  oda_alu oda_alu_i (.clock(clock), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .src1_sel(src1_sel),
    .src2_sel(src2_sel), .dst_sel(dst_sel), .use_imm(use_imm), .imm(imm), .frac_mode(frac_mode),
    .unsigned_mode(unsigned_mode), .round_en(round_en), .negate_en(negate_en), .sat_en(sat_en),
    .cond_true(cond_true), .rd0_valid(rd0_valid), .rd0_sel(rd0_sel), .rd0_data(rd0_data), .rd1_valid(rd1_valid),
    .rd1_sel(rd1_sel), .rd1_data(rd1_data), .wr_sel(wr_sel), .wr_data(wr_data), .flag_carry(flag_carry),
    .flag_zero(flag_zero), .flag_neg(flag_neg), .flag_ovf(flag_ovf), .flag_limit(flag_limit));
  oda_mem_model oda_mem_model_i (.clock(clock), .rq0(rq0), .ad0(ad0), .rq1(rq1), .ad1(ad1), .rd0_valid(rd0_valid),
    .rd0_data(rd0_data), .rd1_valid(rd1_valid), .rd1_data(rd1_data));

  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    n_tests++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Row i is checked while row i+1 issues
  task automatic run(input int lo, input int hi);
    for (int i = lo; i <= hi + 1; i++) begin
      @(posedge clock);
      op_valid <= (i <= hi);
      if (i <= hi) begin
        op_code <= rows[i].op;
        src1_sel <= rows[i].s1;
        src2_sel <= rows[i].s2;
        dst_sel <= rows[i].dst;
        {use_imm, frac_mode, round_en, negate_en, sat_en, cond_true} <= rows[i].fl;
        imm <= rows[i].imm;
      end
      if (i > lo) begin
        wr_sel <= rows[i-1].ws;
        @(negedge clock);
        chk(wr_data, rows[i-1].ex);
      end
    end
    $display("test rows %0d..%0d done", lo, hi);
  endtask

  task automatic ld(input logic [2:0] s0, input logic [1:0] a0, input logic [2:0] s1, input logic [1:0] a1,
                    input logic [15:0] ex);
    @(posedge clock);
    rq0 <= 1'b1;
    ad0 <= a0;
    rd0_sel <= s0;
    rq1 <= 1'b1;
    ad1 <= a1;
    rd1_sel <= s1;
    wr_sel <= s1;
    @(posedge clock);
    rq0 <= 1'b0;
    rq1 <= 1'b0;
    @(negedge clock);
    chk(wr_data, ex);
    $display("test load done");
  endtask

  // ********************
  // Sequence
  // ********************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (1000) @(posedge clock);
    num_errors++;
    $display("watchdog expired");
    final_report;
  end

  initial begin
    {nrst, op_valid, use_imm, frac_mode, unsigned_mode, round_en, negate_en, sat_en, cond_true} = 9'h000;
    {rq0, rq1, ad0, ad1, src1_sel, src2_sel, dst_sel, rd0_sel, rd1_sel, wr_sel} = 21'h000000;
    op_code = oda_pkg::OP_NOP;
    imm = 16'h0000;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(wr_data, 16'h0000);
    chk({11'h000, flag_carry, flag_zero, flag_neg, flag_ovf, flag_limit}, 16'h0000);
    @(posedge clock);
    nrst <= 1'b1;
    $display("test reset done");
    ld(3'h0, 2'h0, 3'h1, 2'h1, 16'h0005);
    run(0, 22);
    ld(3'h0, 2'h2, 3'h1, 2'h3, 16'h4000);
    run(23, 26);
    ld(3'h0, 2'h2, 3'h3, 2'h3, 16'h4000);
    run(27, 28);
    chk({15'h0000, flag_limit}, 16'h0001);
    ld(3'h2, 2'h0, 3'h2, 2'h1, 16'h0005);
    unsigned_mode <= 1'b1;
    run(29, 29);
    final_report;
  end
endmodule

// File: verilog/oda_alu.sv
// Data computation unit: three data registers, two accumulators, immediate operands, single-cycle MAC and ALU.
// Assumes the instruction decoder and data-memory buses run on the same core clock.
// Contract
// - Any arithmetic result may be written to any of the three data registers or two accumulators.
// - The second operand may be an instruction immediate instead of a register.
// - Accumulators may feed the multiplier as source operands.
// - Increment and decrement work on every data register.
// - Fractional, integer, signed, unsigned and carry-chained multiword arithmetic supported.
// - A MAC runs alongside up to two data-memory transfers in one cycle.
// - Multiply and MAC offer optional rounding and product inversion, single cycle.
// - Add, subtract, compare, AND, OR, XOR complete in one cycle.
// - Single-cycle shifts, rotates and a 16-bit variable barrel shift.
// - Negate, complement, abs, round, saturate, conditional move, divide and normalise steps.
// - MAC result is usable by the very next instruction.
// - Multiplies accept two distinct operands or one operand squared.
// - Two 36-bit accumulators with extension bits.
`timescale 1ns/1ps
module oda_alu (
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic                        op_valid,
  input  wire oda_pkg::oda_op_type         op_code,
  input  wire logic [2:0]                  src1_sel,
  input  wire logic [2:0]                  src2_sel,
  input  wire logic [2:0]                  dst_sel,
  input  wire logic                        use_imm,
  input  wire logic [oda_pkg::WORD_W-1:0]  imm,
  input  wire logic                        frac_mode,
  input  wire logic                        unsigned_mode,
  input  wire logic                        round_en,
  input  wire logic                        negate_en,
  input  wire logic                        sat_en,
  input  wire logic                        cond_true,
  input  wire logic                        rd0_valid,
  input  wire logic [2:0]                  rd0_sel,
  input  wire logic [oda_pkg::WORD_W-1:0]  rd0_data,
  input  wire logic                        rd1_valid,
  input  wire logic [2:0]                  rd1_sel,
  input  wire logic [oda_pkg::WORD_W-1:0]  rd1_data,
  input  wire logic [2:0]                  wr_sel,
  output logic      [oda_pkg::WORD_W-1:0]  wr_data,
  output logic                             flag_carry,
  output logic                             flag_zero,
  output logic                             flag_neg,
  output logic                             flag_ovf,
  output logic                             flag_limit
);

  localparam int W = oda_pkg::WORD_W;
  localparam int A = oda_pkg::ACC_W;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [A-1:0] widen(input logic [W-1:0] w, input logic fr);
    widen = fr ? {{4{w[W-1]}}, w, 16'h0000} : {{20{w[W-1]}}, w};
  endfunction

  function automatic logic [W-1:0] word_of(input logic [A-1:0] v, input logic fr);
    word_of = fr ? v[31:16] : v[15:0];
  endfunction

  function automatic logic ext_used(input logic [A-1:0] v);
    ext_used = !((&v[35:31]) || !(|v[35:31]));
  endfunction

  function automatic logic [W-1:0] sat16(input logic [A-1:0] v);
    if (ext_used(v)) begin
      sat16 = v[35] ? oda_pkg::WORD_MIN : oda_pkg::WORD_MAX;
    end else begin
      sat16 = v[31:16];
    end
  endfunction

  // ****************************************************************
  // Register file and read ports
  // ****************************************************************
  logic [W-1:0] data_q [oda_pkg::NUM_DATA];
  logic [A-1:0] acc_q  [oda_pkg::NUM_ACC];
  logic [A-1:0] wide_v [oda_pkg::NUM_REGS];
  logic [W-1:0] word_v [oda_pkg::NUM_REGS];
  logic         carry_q;

  genvar gi;
  generate
    for (gi = 0; gi < oda_pkg::NUM_REGS; gi = gi + 1) begin : g_view
      if (gi < oda_pkg::NUM_DATA) begin : g_data
        assign wide_v[gi] = widen(data_q[gi], frac_mode);
        assign word_v[gi] = data_q[gi];
      end else begin : g_acc
        assign wide_v[gi] = acc_q[gi-oda_pkg::NUM_DATA];
        assign word_v[gi] = word_of(acc_q[gi-oda_pkg::NUM_DATA], frac_mode);
      end
    end
  endgenerate

  logic [A-1:0] x1;
  logic [A-1:0] x2;
  logic [A-1:0] xd;
  logic [W-1:0] w1;
  logic [W-1:0] w2;

  assign x1 = (src1_sel < 3'h5) ? wide_v[src1_sel] : oda_pkg::ACC_RESET;
  assign w1 = (src1_sel < 3'h5) ? word_v[src1_sel] : oda_pkg::WORD_RESET;
  assign w2 = use_imm ? imm : ((src2_sel < 3'h5) ? word_v[src2_sel] : oda_pkg::WORD_RESET);
  assign x2 = use_imm ? widen(imm, frac_mode) : ((src2_sel < 3'h5) ? wide_v[src2_sel] : oda_pkg::ACC_RESET);
  assign xd = (dst_sel < 3'h5) ? wide_v[dst_sel] : oda_pkg::ACC_RESET;

  // Store port shows the pre-update value
  assign wr_data = (wr_sel < 3'h5) ? word_v[wr_sel] : oda_pkg::WORD_RESET;

  // ****************************************************************
  // Multiplier-accumulator
  // ****************************************************************
  oda_mac_if mac_bus ();

  assign mac_bus.mul_a       = w1;
  assign mac_bus.mul_b       = w2;
  assign mac_bus.acc_in      = xd;
  assign mac_bus.accumulate  = (op_code == oda_pkg::OP_MAC);
  assign mac_bus.negate      = negate_en;
  assign mac_bus.round       = round_en;
  assign mac_bus.is_unsigned = unsigned_mode;
  assign mac_bus.frac        = frac_mode;

  oda_mac u_mac (
    .mac (mac_bus)
  );

  // ****************************************************************
  // Operation datapath
  // ****************************************************************
  logic [A-1:0] res_w;
  logic [W-1:0] res_word;
  logic         res_is_word;
  logic         res_write;
  logic         carry_d;
  logic         ovf_d;
  logic         limit_d;
  logic [A:0]   add37;
  logic [A:0]   sub37;
  logic [A-1:0] lsb;
  logic [A-1:0] shl;
  logic         cin;

  assign lsb   = frac_mode ? oda_pkg::FRAC_LSB : oda_pkg::INT_LSB;
  assign cin   = ((op_code == oda_pkg::OP_ADC) || (op_code == oda_pkg::OP_SBC)) ? carry_q : 1'b0;
  assign add37 = {1'b0, x1} + {1'b0, x2} + {{A{1'b0}}, cin};
  assign sub37 = {1'b0, x1} - {1'b0, x2} - {{A{1'b0}}, cin};
  assign shl   = {x1[A-2:0], carry_q};

  always_comb begin
    res_w       = x1;
    res_word    = w1;
    res_is_word = 1'b0;
    res_write   = 1'b1;
    carry_d     = carry_q;
    ovf_d       = 1'b0;
    limit_d     = 1'b0;
    case (op_code)
      oda_pkg::OP_MPY, oda_pkg::OP_MAC: begin
        res_w = mac_bus.result;
      end
      oda_pkg::OP_ADD, oda_pkg::OP_ADC: begin
        res_w   = add37[A-1:0];
        carry_d = add37[A];
        ovf_d   = (x1[A-1] == x2[A-1]) && (add37[A-1] != x1[A-1]);
      end
      oda_pkg::OP_SUB, oda_pkg::OP_SBC, oda_pkg::OP_CMP: begin
        res_w     = sub37[A-1:0];
        carry_d   = sub37[A];
        ovf_d     = (x1[A-1] != x2[A-1]) && (sub37[A-1] != x1[A-1]);
        res_write = (op_code != oda_pkg::OP_CMP);
      end
      oda_pkg::OP_AND: begin
        res_word    = w1 & w2;
        res_is_word = 1'b1;
      end
      oda_pkg::OP_OR: begin
        res_word    = w1 | w2;
        res_is_word = 1'b1;
      end
      oda_pkg::OP_EOR: begin
        res_word    = w1 ^ w2;
        res_is_word = 1'b1;
      end
      oda_pkg::OP_ASL: begin
        res_w   = {x1[A-2:0], 1'b0};
        carry_d = x1[A-1];
        ovf_d   = x1[A-1] != x1[A-2];
      end
      oda_pkg::OP_ASR: begin
        res_w   = {x1[A-1], x1[A-1:1]};
        carry_d = x1[0];
      end
      oda_pkg::OP_LSL, oda_pkg::OP_ROL: begin
        res_word    = {w1[W-2:0], (op_code == oda_pkg::OP_ROL) ? carry_q : 1'b0};
        res_is_word = 1'b1;
        carry_d     = w1[W-1];
      end
      oda_pkg::OP_LSR, oda_pkg::OP_ROR: begin
        res_word    = {(op_code == oda_pkg::OP_ROR) ? carry_q : 1'b0, w1[W-1:1]};
        res_is_word = 1'b1;
        carry_d     = w1[0];
      end
      oda_pkg::OP_BSL: begin
        res_word    = w1 << w2[3:0];
        res_is_word = 1'b1;
      end
      oda_pkg::OP_BSRA: begin
        res_word    = W'($signed(w1) >>> w2[3:0]);
        res_is_word = 1'b1;
      end
      oda_pkg::OP_BSRL: begin
        res_word    = w1 >> w2[3:0];
        res_is_word = 1'b1;
      end
      oda_pkg::OP_INC: begin
        res_w = x1 + lsb;
        ovf_d = !x1[A-1] && res_w[A-1];
      end
      oda_pkg::OP_DEC: begin
        res_w = x1 - lsb;
        ovf_d = x1[A-1] && !res_w[A-1];
      end
      oda_pkg::OP_NEG: begin
        res_w = ~x1 + oda_pkg::INT_LSB;
      end
      oda_pkg::OP_NOT: begin
        res_word    = ~w1;
        res_is_word = 1'b1;
      end
      oda_pkg::OP_ABS: begin
        res_w = x1[A-1] ? (~x1 + oda_pkg::INT_LSB) : x1;
      end
      oda_pkg::OP_RND: begin
        res_w = (x1 + oda_pkg::RND_CONST) & ~oda_pkg::LOW_MASK;
      end
      oda_pkg::OP_SAT: begin
        res_w   = ext_used(x1) ? widen(sat16(x1), 1'b1) : x1;
        limit_d = ext_used(x1);
      end
      oda_pkg::OP_TCC: begin
        res_write = cond_true;
      end
      oda_pkg::OP_DIV: begin
        // One restoring-free step; quotient bit lands in carry
        res_w   = (x1[A-1] ^ x2[A-1]) ? (shl + x2) : (shl - x2);
        carry_d = !(res_w[A-1] ^ x2[A-1]);
      end
      oda_pkg::OP_NORM: begin
        // Shift only while the value is not yet normalised
        if (!ext_used(x1) && (x1[31] == x1[30]) && (x1 != oda_pkg::ACC_RESET)) begin
          res_w = {x1[A-2:0], 1'b0};
        end
      end
      default: begin
        res_write = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Write-back values
  // ****************************************************************
  logic [A-1:0] wb_wide;
  logic [W-1:0] wb_word;
  logic         wb_limit;
  logic         alu_we;

  assign alu_we   = op_valid && res_write && (dst_sel < 3'h5);
  assign wb_wide  = res_is_word ? widen(res_word, frac_mode) : res_w;
  assign wb_limit = !res_is_word && frac_mode && sat_en && ext_used(res_w);
  // Limiting into 16-bit registers only in fractional mode
  assign wb_word  = res_is_word ? res_word
                  : (frac_mode ? (sat_en ? sat16(res_w) : res_w[31:16]) : res_w[15:0]);

  // ****************************************************************
  // Data registers
  // ****************************************************************
  // Later write wins: ALU over rd1 over rd0
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < oda_pkg::NUM_DATA; i++) begin
        data_q[i] <= oda_pkg::WORD_RESET;
      end
    end else begin
      if (rd0_valid && (rd0_sel < 3'h3)) begin
        data_q[rd0_sel[1:0]] <= rd0_data;
      end
      if (rd1_valid && (rd1_sel < 3'h3)) begin
        data_q[rd1_sel[1:0]] <= rd1_data;
      end
      if (alu_we && (dst_sel < 3'h3)) begin
        data_q[dst_sel[1:0]] <= wb_word;
      end
    end
  end

  // ****************************************************************
  // Accumulators
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < oda_pkg::NUM_ACC; i++) begin
        acc_q[i] <= oda_pkg::ACC_RESET;
      end
    end else begin
      if (rd0_valid && (rd0_sel == oda_pkg::REG_A || rd0_sel == oda_pkg::REG_B)) begin
        acc_q[rd0_sel == oda_pkg::REG_B] <= widen(rd0_data, 1'b1);
      end
      if (rd1_valid && (rd1_sel == oda_pkg::REG_A || rd1_sel == oda_pkg::REG_B)) begin
        acc_q[rd1_sel == oda_pkg::REG_B] <= widen(rd1_data, 1'b1);
      end
      if (alu_we && (dst_sel == oda_pkg::REG_A || dst_sel == oda_pkg::REG_B)) begin
        acc_q[dst_sel == oda_pkg::REG_B] <= wb_wide;
      end
    end
  end

  // ****************************************************************
  // Condition flags
  // ****************************************************************
  assign flag_carry = carry_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      carry_q    <= 1'b0;
      flag_zero  <= 1'b0;
      flag_neg   <= 1'b0;
      flag_ovf   <= 1'b0;
      flag_limit <= 1'b0;
    end else if (op_valid && (op_code != oda_pkg::OP_NOP) && (op_code != oda_pkg::OP_TCC)) begin
      carry_q    <= carry_d;
      flag_zero  <= res_is_word ? (res_word == oda_pkg::WORD_RESET) : (res_w == oda_pkg::ACC_RESET);
      flag_neg   <= res_is_word ? res_word[W-1] : res_w[A-1];
      flag_ovf   <= ovf_d;
      // Sticky until reset so any clipping in a block, except on a conditional move, shows
      flag_limit <= flag_limit | limit_d | (wb_limit && (dst_sel < 3'h3));
    end
  end

endmodule

// File: verilog/oda_alu_dummy_guard.sv
// Empty; no logic lives here.

// File: verilog/oda_mac.sv
// Single-cycle multiplier-accumulator, no pipeline stage inside.
// Assumes the caller registers the result at the end of the instruction cycle.
`timescale 1ns/1ps
module oda_mac (
  oda_mac_if.mac mac
);

  logic signed [oda_pkg::WORD_W:0]     a_ext;
  logic signed [oda_pkg::WORD_W:0]     b_ext;
  logic signed [2*oda_pkg::WORD_W+1:0] prod;
  logic        [oda_pkg::ACC_W-1:0]    prod_w;
  logic        [oda_pkg::ACC_W-1:0]    prod_n;
  logic        [oda_pkg::ACC_W-1:0]    sum;

  // ****************************************************************
  // Product
  // ****************************************************************
  // Extra top bit lets one signed multiplier serve unsigned operands too
  assign a_ext  = {mac.is_unsigned ? 1'b0 : mac.mul_a[oda_pkg::WORD_W-1], mac.mul_a};
  assign b_ext  = {mac.is_unsigned ? 1'b0 : mac.mul_b[oda_pkg::WORD_W-1], mac.mul_b};
  assign prod   = a_ext * b_ext;
  // Fractional product drops the duplicate sign bit
  assign prod_w = mac.frac ? {prod[2*oda_pkg::WORD_W+1], prod, 1'b0}
                           : {{2{prod[2*oda_pkg::WORD_W+1]}}, prod};
  assign prod_n = mac.negate ? (~prod_w + oda_pkg::INT_LSB) : prod_w;

  // ****************************************************************
  // Accumulate and round
  // ****************************************************************
  assign sum        = mac.accumulate ? (mac.acc_in + prod_n) : prod_n;
  assign mac.result = mac.round ? ((sum + oda_pkg::RND_CONST) & ~oda_pkg::LOW_MASK) : sum;

endmodule

// File: verilog/oda_mac_if.sv
// Link from the datapath to its multiplier-accumulator.
// Assumes both ends sit on the same core clock; the link is purely combinational.
`timescale 1ns/1ps
interface oda_mac_if;
  logic [oda_pkg::WORD_W-1:0] mul_a;
  logic [oda_pkg::WORD_W-1:0] mul_b;
  logic [oda_pkg::ACC_W-1:0]  acc_in;
  logic                       accumulate;
  logic                       negate;
  logic                       round;
  logic                       is_unsigned;
  logic                       frac;
  logic [oda_pkg::ACC_W-1:0]  result;

  modport alu (output mul_a, output mul_b, output acc_in, output accumulate, output negate,
               output round, output is_unsigned, output frac, input result);
  modport mac (input mul_a, input mul_b, input acc_in, input accumulate, input negate,
               input round, input is_unsigned, input frac, output result);
endinterface

// File: verilog/oda_pkg.sv
// Constants, operation codes and register selects of the data computation unit.
// Assumes nothing of its surroundings; used by every design file as oda_pkg::name.
package oda_pkg;

  // ****************************************************************
  // Widths and constants
  // ****************************************************************
  localparam int WORD_W   = 16;
  localparam int ACC_W    = 36;
  localparam int NUM_DATA = 3;
  localparam int NUM_ACC  = 2;
  localparam int NUM_REGS = NUM_DATA + NUM_ACC;

  localparam logic [ACC_W-1:0]  ACC_RESET  = 36'h000000000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [ACC_W-1:0]  RND_CONST  = 36'h000008000;
  localparam logic [ACC_W-1:0]  LOW_MASK   = 36'h00000ffff;
  localparam logic [ACC_W-1:0]  FRAC_LSB   = 36'h000010000;
  localparam logic [ACC_W-1:0]  INT_LSB    = 36'h000000001;
  localparam logic [WORD_W-1:0] WORD_MAX   = 16'h7fff;
  localparam logic [WORD_W-1:0] WORD_MIN   = 16'h8000;

  // ****************************************************************
  // Register selects
  // ****************************************************************
  typedef enum logic [2:0] {
    REG_X0 = 3'h0,
    REG_Y0 = 3'h1,
    REG_Y1 = 3'h2,
    REG_A  = 3'h3,
    REG_B  = 3'h4
  } oda_reg_type;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP  = 5'h00,
    OP_MPY  = 5'h01,
    OP_MAC  = 5'h02,
    OP_ADD  = 5'h03,
    OP_ADC  = 5'h04,
    OP_SUB  = 5'h05,
    OP_SBC  = 5'h06,
    OP_CMP  = 5'h07,
    OP_AND  = 5'h08,
    OP_OR   = 5'h09,
    OP_EOR  = 5'h0a,
    OP_ASL  = 5'h0b,
    OP_ASR  = 5'h0c,
    OP_LSL  = 5'h0d,
    OP_LSR  = 5'h0e,
    OP_ROL  = 5'h0f,
    OP_ROR  = 5'h10,
    OP_BSL  = 5'h11,
    OP_BSRA = 5'h12,
    OP_BSRL = 5'h13,
    OP_INC  = 5'h14,
    OP_DEC  = 5'h15,
    OP_NEG  = 5'h16,
    OP_NOT  = 5'h17,
    OP_ABS  = 5'h18,
    OP_RND  = 5'h19,
    OP_SAT  = 5'h1a,
    OP_TCC  = 5'h1b,
    OP_DIV  = 5'h1c,
    OP_NORM = 5'h1d
  } oda_op_type;

endpackage
